// ---- inc/wdtu_pkg.sv ----
// Package of register map, field layout and timing constants for the watchdog timeout unit
package wdtu_pkg;

    // ****************************************************************
    // Register offsets (word numbers, compared with byte address bits 5:2, one aligned word each)
    // ****************************************************************
    localparam logic [3:0] OFF_CLOCK_CTRL = 4'h0;
    localparam logic [3:0] OFF_GUARD_CTRL = 4'h1;
    localparam logic [3:0] OFF_POWER_MGMT = 4'h2;
    localparam logic [3:0] OFF_ACCESS_KEY = 4'h3;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h5;
    localparam logic [3:0] OFF_IRQ_CLEAR  = 4'h6;
    localparam logic [3:0] OFF_COUNT_LO   = 4'h7;
    localparam logic [3:0] OFF_COUNT_HI   = 4'h8;
    localparam int         ADDR_W         = 6;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CK_PERIOD_HI   = 7;
    localparam int CK_PERIOD_LO   = 6;
    localparam int GD_IRQ_FLAG    = 3;
    localparam int GD_RST_FLAG    = 2;
    localparam int GD_RST_ENABLE  = 1;
    localparam int GD_RESTART     = 0;
    localparam int PM_DIV_HI      = 7;
    localparam int PM_DIV_LO      = 6;
    localparam int PM_MULT        = 3;
    localparam int ST_IRQ         = 0;
    localparam int ST_RST         = 1;

    // ****************************************************************
    // Reset values and keys
    // ****************************************************************
    localparam logic [7:0] CLOCK_CTRL_RST = 8'h00;
    localparam logic [7:0] POWER_MGMT_RST = 8'h80;
    localparam logic [7:0] KEY_FIRST      = 8'hAA;
    localparam logic [7:0] KEY_SECOND     = 8'h55;
    localparam logic [2:0] KEY_WINDOW     = 3'h4;

    // ****************************************************************
    // Timeout constants
    // ****************************************************************
    localparam int          COUNT_W        = 35;
    localparam logic [9:0]  RESET_GAP      = 10'h200;
    localparam logic [5:0]  EXP_BASE_MULT  = 6'h0F;
    localparam logic [5:0]  EXP_BASE_SLOW  = 6'h10;
    localparam logic [5:0]  EXP_BASE_MID   = 6'h11;
    localparam logic [5:0]  EXP_BASE_PMM   = 6'h19;
    localparam logic [5:0]  EXP_STEP       = 6'h03;

    // Access unlock states
    typedef enum logic [1:0]
    {
        WDTU_KEY_IDLE  = 2'b00,
        WDTU_KEY_HALF  = 2'b01,
        WDTU_KEY_OPEN  = 2'b10
    } wdtu_key_e;

endpackage

// ---- rtl/wdtu_timer.sv ----
// Watchdog counter chain: timeout detection and 512-clock reset delay
module wdtu_timer
#(
    parameter int COUNT_W = wdtu_pkg::COUNT_W
)
(
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    input  wire logic               ce_in,
    input  wire logic               restart_in,
    input  wire logic [5:0]         exp_in,
    output logic      [COUNT_W-1:0] count_out,
    output logic                    irq_set_out,
    output logic                    rst_set_out
);

    logic [COUNT_W-1:0] count_reg;
    logic [9:0]         gap_reg;
    logic               gap_run_reg;
    logic               hit;

    // Full count reached when the count equals 2^exp - 1
    assign hit = (count_reg == ((COUNT_W'(1) << exp_in) - COUNT_W'(1)));

    // ****************************************************************
    // Free running counter; restart returns it to zero
    // ****************************************************************
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            count_reg <= '0;
        else if (ce_in)
        begin
            if (restart_in || hit)
                count_reg <= '0;
            else
                count_reg <= count_reg + COUNT_W'(1);
        end
    end

    // Reset flag follows the timeout by a fixed clock gap; restart cancels it
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gap_reg     <= '0;
            gap_run_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            if (restart_in)
                gap_run_reg <= 1'b0;
            else if (hit)
            begin
                gap_run_reg <= 1'b1;
                gap_reg     <= wdtu_pkg::RESET_GAP - 10'h001;
            end
            else if (gap_run_reg)
            begin
                if (gap_reg == 10'h000)
                    gap_run_reg <= 1'b0;
                else
                    gap_reg <= gap_reg - 10'h001;
            end
        end
    end

    assign count_out   = count_reg;
    assign irq_set_out = ce_in && hit && !restart_in;
    assign rst_set_out = ce_in && gap_run_reg && gap_reg == 10'h000 && !restart_in;

endmodule

// ---- rtl/wdtu_top.sv ----
// Watchdog timeout unit top: Avalon-MM registers, timed access, flags and reset request
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
module wdtu_top
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        CE_IN,
    input  wire logic [5:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    output logic             IRQ_OUT,
    output logic             WAKE_OUT,
    output logic             CPU_RESET_OUT
);

    // ****************************************************************
    // Reset release and local state
    // ****************************************************************
    logic                          rst_meta_reg;
    logic                          rst_sync_reg;
    logic [7:0]                    clock_ctrl_reg;
    logic [7:0]                    power_mgmt_reg;
    logic                          timeout_irq_flag_reg;
    logic                          timeout_reset_flag_reg;
    logic                          timeout_reset_enable_reg;
    logic                          timeout_irq_enable_reg;
    logic                          rst_status_enable_reg;
    logic                          rst_status_reg;
    wdtu_pkg::wdtu_key_e           key_state_reg;
    logic [2:0]                    key_timer_reg;
    logic                          ack_reg;
    logic                          restart;
    logic                          irq_set;
    logic                          rst_set;
    logic [wdtu_pkg::COUNT_W-1:0]  count;
    logic [5:0]                    exp_sel;
    logic                          wr_hit;
    logic                          rd_hit;
    logic [3:0]                    word;
    logic                          key_open;
    logic [7:0]                    wbyte;

    // Reset released through two flops; assertion stays asynchronous
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // Bus decode: one wait state, then the answer at the acknowledging edge
    // ****************************************************************
    assign word     = AVS_ADDRESS_IN[5:2];
    assign wbyte    = AVS_BYTEENABLE_IN[0] ? AVS_WRITEDATA_IN[7:0] : 8'h00;
    assign wr_hit   = CE_IN && AVS_WRITE_IN && ack_reg && AVS_BYTEENABLE_IN[0];
    assign rd_hit   = CE_IN && AVS_READ_IN && !ack_reg;
    assign key_open = (key_state_reg == wdtu_pkg::WDTU_KEY_OPEN);

    // Exponent of the timeout from period, divide and multiplier bits
    function automatic logic [5:0] timeout_exp(input logic [1:0] period, input logic [1:0] div, input logic mult);
        logic [5:0] base;
        base = 6'h00;
        case (div)
            2'b00:   base = mult ? wdtu_pkg::EXP_BASE_MULT : wdtu_pkg::EXP_BASE_SLOW;
            2'b01:   base = wdtu_pkg::EXP_BASE_MID;
            2'b10:   base = wdtu_pkg::EXP_BASE_MID;
            default: base = wdtu_pkg::EXP_BASE_PMM;
        endcase
        timeout_exp = base + 6'(period) * wdtu_pkg::EXP_STEP;
    endfunction

    assign exp_sel = timeout_exp({clock_ctrl_reg[wdtu_pkg::CK_PERIOD_HI], clock_ctrl_reg[wdtu_pkg::CK_PERIOD_LO]},
                                 {power_mgmt_reg[wdtu_pkg::PM_DIV_HI], power_mgmt_reg[wdtu_pkg::PM_DIV_LO]},
                                 power_mgmt_reg[wdtu_pkg::PM_MULT]);

    // Restart is a write of the restart bit while the timed-access window is open
    assign restart = wr_hit && word == wdtu_pkg::OFF_GUARD_CTRL && key_open
                     && wbyte[wdtu_pkg::GD_RESTART];

    wdtu_timer
    #(
        .COUNT_W (wdtu_pkg::COUNT_W)
    )
    u_timer
    (
        .clk_in      (CLK_IN),
        .rst_b_in    (rst_sync_reg),
        .ce_in       (CE_IN),
        .restart_in  (restart),
        .exp_in      (exp_sel),
        .count_out   (count),
        .irq_set_out (irq_set),
        .rst_set_out (rst_set)
    );

    // Waitrequest handshake: each request gets exactly one acknowledge cycle
    // Waitrequest is its own flop so the port never sees a gate after the register
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            ack_reg             <= 1'b0;
            AVS_WAITREQUEST_OUT <= 1'b1;
        end
        else if (CE_IN)
        begin
            ack_reg             <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;
            AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) && !ack_reg);
        end
    end

    // ****************************************************************
    // Timed access: two key writes open a short window for protected bits
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            key_state_reg <= wdtu_pkg::WDTU_KEY_IDLE;
            key_timer_reg <= 3'h0;
        end
        else if (CE_IN)
        begin
            if (wr_hit && word == wdtu_pkg::OFF_ACCESS_KEY)
            begin
                key_timer_reg <= wdtu_pkg::KEY_WINDOW;
                if (wbyte == wdtu_pkg::KEY_FIRST)
                    key_state_reg <= wdtu_pkg::WDTU_KEY_HALF;
                else if (wbyte == wdtu_pkg::KEY_SECOND && key_state_reg == wdtu_pkg::WDTU_KEY_HALF)
                    key_state_reg <= wdtu_pkg::WDTU_KEY_OPEN;
                else
                    key_state_reg <= wdtu_pkg::WDTU_KEY_IDLE;
            end
            else if (key_state_reg != wdtu_pkg::WDTU_KEY_IDLE)
            begin
                // Window closes on timeout; a used window is spent
                if (key_timer_reg == 3'h0 || (wr_hit && word == wdtu_pkg::OFF_GUARD_CTRL && key_open))
                    key_state_reg <= wdtu_pkg::WDTU_KEY_IDLE;
                else
                    key_timer_reg <= key_timer_reg - 3'h1;
                case (key_state_reg)
                    wdtu_pkg::WDTU_KEY_HALF: ;
                    wdtu_pkg::WDTU_KEY_OPEN: ;
                    default:                 ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Unprotected configuration registers
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            clock_ctrl_reg         <= wdtu_pkg::CLOCK_CTRL_RST;
            power_mgmt_reg         <= wdtu_pkg::POWER_MGMT_RST;
            timeout_irq_enable_reg <= 1'b0;
            rst_status_enable_reg  <= 1'b0;
        end
        else if (CE_IN && wr_hit)
        begin
            if (word == wdtu_pkg::OFF_CLOCK_CTRL)
                clock_ctrl_reg <= wbyte;
            if (word == wdtu_pkg::OFF_POWER_MGMT)
                power_mgmt_reg <= wbyte;
            if (word == wdtu_pkg::OFF_IRQ_ENABLE)
            begin
                timeout_irq_enable_reg <= wbyte[wdtu_pkg::ST_IRQ];
                rst_status_enable_reg  <= wbyte[wdtu_pkg::ST_RST];
            end
        end
    end

    // Reset enable changes only inside an open timed-access window
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            timeout_reset_enable_reg <= 1'b0;
        else if (CE_IN && wr_hit && word == wdtu_pkg::OFF_GUARD_CTRL && key_open)
            timeout_reset_enable_reg <= wbyte[wdtu_pkg::GD_RST_ENABLE];
    end

    // ****************************************************************
    // Sticky flags: a hardware set wins over a software clear
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            timeout_irq_flag_reg   <= 1'b0;
            timeout_reset_flag_reg <= 1'b0;
            rst_status_reg         <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (irq_set)
                timeout_irq_flag_reg <= 1'b1;
            else if (wr_hit && word == wdtu_pkg::OFF_IRQ_CLEAR && wbyte[wdtu_pkg::ST_IRQ])
                timeout_irq_flag_reg <= 1'b0;
            if (rst_set)
                timeout_reset_flag_reg <= 1'b1;
            else if (wr_hit && word == wdtu_pkg::OFF_GUARD_CTRL && !wbyte[wdtu_pkg::GD_RST_FLAG])
                timeout_reset_flag_reg <= 1'b0;
            if (rst_set)
                rst_status_reg <= 1'b1;
            else if (wr_hit && word == wdtu_pkg::OFF_IRQ_CLEAR && wbyte[wdtu_pkg::ST_RST])
                rst_status_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs, all registered
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            IRQ_OUT       <= 1'b0;
            WAKE_OUT      <= 1'b0;
            CPU_RESET_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            IRQ_OUT       <= (timeout_irq_flag_reg && timeout_irq_enable_reg)
                             || (rst_status_reg && rst_status_enable_reg);
            WAKE_OUT      <= timeout_irq_flag_reg && timeout_irq_enable_reg;
            CPU_RESET_OUT <= rst_set && timeout_reset_enable_reg;
        end
    end

    // Read data: captured in the wait cycle, presented at the acknowledge edge
    always_ff @(posedge CLK_IN or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            AVS_READDATA_OUT <= 32'h00000000;
        else if (rd_hit)
        begin
            case (word)
                wdtu_pkg::OFF_CLOCK_CTRL: AVS_READDATA_OUT <= {24'h000000, clock_ctrl_reg};
                wdtu_pkg::OFF_GUARD_CTRL: AVS_READDATA_OUT <= {28'h0000000, timeout_irq_flag_reg,
                                                               timeout_reset_flag_reg, timeout_reset_enable_reg, 1'b0};
                wdtu_pkg::OFF_POWER_MGMT: AVS_READDATA_OUT <= {24'h000000, power_mgmt_reg};
                wdtu_pkg::OFF_IRQ_STATUS: AVS_READDATA_OUT <= {30'h00000000, rst_status_reg, timeout_irq_flag_reg};
                wdtu_pkg::OFF_IRQ_ENABLE: AVS_READDATA_OUT <= {30'h00000000, rst_status_enable_reg,
                                                               timeout_irq_enable_reg};
                wdtu_pkg::OFF_COUNT_LO:   AVS_READDATA_OUT <= count[31:0];
                wdtu_pkg::OFF_COUNT_HI:   AVS_READDATA_OUT <= {29'h00000000, count[34:32]};
                default:                  AVS_READDATA_OUT <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reset_needs_enable;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        CPU_RESET_OUT |-> $past(timeout_reset_enable_reg);
    endproperty
    a_reset_needs_enable: assert property (p_reset_needs_enable) else $error("reset without enable");

    property p_reset_after_irq;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        (CE_IN && rst_set) |-> $past(timeout_irq_flag_reg) || $past(irq_set, 512);
    endproperty
    a_reset_after_irq: assert property (p_reset_after_irq) else $error("reset flag without irq");

    property p_irq_sticky;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        (timeout_irq_flag_reg && !(wr_hit && word == wdtu_pkg::OFF_IRQ_CLEAR)) |=> timeout_irq_flag_reg;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag lost");

    property p_irq_set;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        irq_set |=> timeout_irq_flag_reg;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq flag not set");

    property p_restart_zero;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        (CE_IN && restart) |=> count == '0;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("restart did not clear count");

    property p_enable_guarded;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        $changed(timeout_reset_enable_reg) |-> $past(key_open);
    endproperty
    a_enable_guarded: assert property (p_enable_guarded) else $error("unguarded enable change");

    property p_irq_independent;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        (CE_IN && timeout_irq_flag_reg && timeout_irq_enable_reg) |=> IRQ_OUT && WAKE_OUT;
    endproperty
    a_irq_independent: assert property (p_irq_independent) else $error("irq not raised");

    property p_count_runs;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        (CE_IN && !restart && !irq_set) |=> count == $past(count) + 35'h1;
    endproperty
    a_count_runs: assert property (p_count_runs) else $error("counter stalled");

    property p_wake_follows;
        @(posedge CLK_IN) disable iff (!rst_sync_reg)
        (CE_IN && !(timeout_irq_flag_reg && timeout_irq_enable_reg)) |=> !WAKE_OUT;
    endproperty
    a_wake_follows: assert property (p_wake_follows) else $error("wake without enabled flag");

    c_irq:     cover property (@(posedge CLK_IN) irq_set);
    c_reset:   cover property (@(posedge CLK_IN) CPU_RESET_OUT);
    c_restart: cover property (@(posedge CLK_IN) restart);
    c_masked:  cover property (@(posedge CLK_IN) timeout_irq_flag_reg && !timeout_irq_enable_reg);
    c_keyed:   cover property (@(posedge CLK_IN) key_open);

endmodule

// ---- bench/wdtu_top_tb.sv ----
// Self-checking testbench for the watchdog timeout unit top
module wdtu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and clock
    // ****************************************************************
    logic        CLK_IN = 1'b0;
    logic        RST_B_IN = 1'b0;
    logic        CE_IN = 1'b1;
    logic [5:0]  AVS_ADDRESS_IN = 6'h00;
    logic        AVS_READ_IN = 1'b0;
    logic        AVS_WRITE_IN = 1'b0;
    logic [31:0] AVS_WRITEDATA_IN = 32'h0;
    logic [31:0] AVS_READDATA_OUT;
    logic        AVS_WAITREQUEST_OUT;
    logic        IRQ_OUT;
    logic        WAKE_OUT;
    logic        CPU_RESET_OUT;
    logic [31:0] rd;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t0;
    int          n;
    always #5 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN) cyc <= cyc + 1;
    // Byte lanes held on: only the low byte carries register data
    wdtu_top i_wdtu_top (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
        .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
        .IRQ_OUT(IRQ_OUT), .WAKE_OUT(WAKE_OUT), .CPU_RESET_OUT(CPU_RESET_OUT));
    // ****************************************************************
    // Report, compare and bus tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Cycle distances are the bench's own counts, so a range is enough
    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        n_compared++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("mismatch at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask
    // Request is held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK_IN);
        AVS_ADDRESS_IN <= a;
        AVS_WRITEDATA_IN <= d;
        AVS_WRITE_IN <= wr;
        AVS_READ_IN <= !wr;
        // Waitrequest and read data are taken at the same rising edge, then released
        for (k = 0; k < 50; k++)
        begin
            @(posedge CLK_IN);
            if (AVS_WAITREQUEST_OUT === 1'b0)
                break;
        end
        rd = AVS_READDATA_OUT;
        AVS_READ_IN <= 1'b0;
        AVS_WRITE_IN <= 1'b0;
        if (k == 50)
        begin
            chk(32'h1, 32'h0, "bus timeout");
            give_verdict();
        end
    endtask
    // Bounded wait for wake (sel 0) or reset pulse (sel 1); a miss fails only when must is set
    task automatic wait_for(input bit sel, input int lim, input bit must, output int cnt);
        for (cnt = 1; cnt <= lim; cnt++)
        begin
            @(negedge CLK_IN);
            if ((sel ? CPU_RESET_OUT : WAKE_OUT) === 1'b1)
                return;
        end
        if (must)
        begin
            chk(32'h1, 32'h0, "event timeout");
            give_verdict();
        end
    endtask
    // Timed access: both keys, then one guard write inside the window
    task automatic guard_write(input logic [31:0] d);
        bus(1'b1, 6'h0C, 32'hAA);
        bus(1'b1, 6'h0C, 32'h55);
        bus(1'b1, 6'h04, d);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge CLK_IN);
        RST_B_IN <= 1'b1;
        repeat (3) @(posedge CLK_IN);
        bus(1'b0, 6'h00, 32'h0);
        chk(rd & 32'hFF, 32'h00, "clock ctrl reset");
        bus(1'b0, 6'h08, 32'h0);
        chk(rd & 32'hFF, 32'h80, "power mgmt reset");
        bus(1'b1, 6'h24, 32'hFF);
        bus(1'b0, 6'h24, 32'h0);
        chk(rd, 32'h0, "unmapped word");
        bus(1'b1, 6'h04, 32'h03);
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'h2, 32'h0, "enable without key");
        // Clock enable low freezes the counter: only the bus cycles around the pause may count
        bus(1'b0, 6'h1C, 32'h0);
        t0 = rd;
        CE_IN <= 1'b0;
        repeat (200) @(posedge CLK_IN);
        CE_IN <= 1'b1;
        bus(1'b0, 6'h1C, 32'h0);
        chk_rng(rd - t0, 1, 20, "count across clock enable low");
        $display("test reset values and refusals done");
        // Shortest timeout keeps the run short: divide 00, multiplier set, period 0
        bus(1'b1, 6'h08, 32'h08);
        bus(1'b1, 6'h00, 32'h00);
        bus(1'b1, 6'h14, 32'h01);
        guard_write(32'h03);
        repeat (10000) @(posedge CLK_IN);
        guard_write(32'h03);
        t0 = cyc;
        bus(1'b0, 6'h1C, 32'h0);
        chk(rd & 32'hFFFF_FFE0, 32'h0, "count after restart");
        wait_for(1'b0, 40000, 1'b1, n);
        chk_rng(cyc - t0, 32768, 32776, "irq timeout");
        chk({31'h0, IRQ_OUT}, 32'h1, "irq line");
        // Wake lags the interrupt flag by one register stage; the reset pulse rises with the reset flag
        wait_for(1'b1, 600, 1'b1, n);
        chk_rng(n, 511, 511, "reset gap");
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'hE, 32'hE, "guard flags");
        bus(1'b0, 6'h10, 32'h0);
        chk(rd & 32'h3, 32'h3, "status flags");
        $display("test timeout with reset done");
        // Masking hides the request but the flag stays until software clears it
        bus(1'b1, 6'h14, 32'h02);
        repeat (3) @(negedge CLK_IN);
        chk({31'h0, WAKE_OUT}, 32'h0, "masked wake");
        chk({31'h0, IRQ_OUT}, 32'h1, "reset status irq");
        bus(1'b0, 6'h10, 32'h0);
        chk(rd & 32'h1, 32'h1, "flag stays set");
        bus(1'b1, 6'h18, 32'h03);
        bus(1'b0, 6'h10, 32'h0);
        chk(rd & 32'h3, 32'h0, "flags cleared");
        chk({31'h0, IRQ_OUT}, 32'h0, "irq line after clear");
        bus(1'b1, 6'h14, 32'h01);
        $display("test mask and clear done");
        // Restart with reset disabled and reset flag cleared
        guard_write(32'h01);
        t0 = cyc;
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'h6, 32'h0, "reset off, flag cleared");
        wait_for(1'b0, 40000, 1'b1, n);
        chk_rng(cyc - t0, 32768, 32776, "second timeout");
        wait_for(1'b1, 600, 1'b0, n);
        chk_rng(n, 601, 601, "no reset pulse");
        bus(1'b0, 6'h04, 32'h0);
        chk(rd & 32'h6, 32'h4, "reset flag without reset");
        $display("test reset disabled done");
        give_verdict();
    end
endmodule
